// ---- rtl/fbc_supervisor.sv ----
// Mode selection, mains supervision and protection sequencing.
// Assumes analogue comparators deliver synchronous level inputs.
`timescale 1ns/1ps
`default_nettype none

// Function
// - One mains sample per millisecond, pin grounded
// - Switch only after mains above brown-in
// - 30 ms continuous low mains: brownout, stop
// - Threshold crossing between samples proves mains
// - Pause sampling 6 ms, 97 ms in burst
// - 28 ms without slope: ground pin continuously
// - Valley mode waits demag then valley
// - Maximum frequency moves valley mode to DISCONTINUOUS_CONDUCTION_MODE
// - Slow oscillator, floor 25 kHz, valleys kept
// - Burst at low power, 25 kHz floor
// - Cycle sections say what winding shows
// - Protection halts switching, restart or latch
// - Regulate supply via mains pin when stopped
// - External fault latches after filter, regulated
// - Overvoltage sampled during secondary stroke
// - Overvoltage confirmed after 4 consecutive pulses
// - Fault delay counts ms ticks in band
// - Upper reference exceeded ends gate pulse
// - Lower reference runs 200 ms overpower timer
// - Startup: 100 percent limit, 40 ms timeout
// - Regulated output: 150 percent, 200 ms timeout
// - Overpower with undervoltage trips at once
// - Mains removal clears latch, shortens restart
// - Safe restart waits 800 ms then rechecks
module fbc_supervisor #(
    parameter int unsigned TICK_CYC = fbc_pkg::TICK_CYC,
    parameter int unsigned PER_W = 12
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Mains sense front end
    input wire fbc_pkg::fbc_mains_t mains_i,
    output logic mains_sense_pin_o,
    output logic mains_sample_o,
    output logic supply_regulate_o,
    // Load and winding sense
    input wire fbc_pkg::fbc_load_t load_i,
    input wire logic demag_i,
    input wire logic valley_i,
    input wire logic overvoltage_protection_i,
    input wire logic [PER_W-1:0] osc_period_i,
    // Current sense comparators
    input wire logic above_cycle_limit_reference_i,
    input wire logic above_overpower_timer_reference_i,
    // Supply and fault inputs
    input wire logic undervoltage_lockout_i,
    input wire logic fb_below_5v_i,
    input wire logic fault_detect_i,
    input wire logic fault_above_power_down_threshold_i,
    input wire logic max_on_time_i,
    // Gate drive and status
    output logic gate_o,
    output fbc_pkg::fbc_mode_t mode_o,
    output fbc_pkg::fbc_state_t state_o,
    output fbc_pkg::fbc_section_t section_o,
    output logic brownout_o,
    output logic mains_present_o,
    output logic ovp_latched_o,
    output logic [1:0] power_limit_o
);
    localparam int unsigned TW = $clog2(TICK_CYC + 1);

    logic [TW-1:0] tick_cnt_q;
    logic tick_q;
    logic [6:0] pause_q;
    logic [4:0] low_cnt_q;
    logic [4:0] slope_cnt_q;
    logic [1:0] prev_q;
    logic disc_q;
    logic [1:0] filt_cnt_q;
    logic [2:0] ovp_cnt_q;
    logic [7:0] opp_cnt_q;
    logic [9:0] rst_cnt_q;
    logic started_q;
    logic [PER_W-1:0] per_cnt_q;
    logic sample_now;
    logic protect_ok;
    logic opp_trip;
    logic mains_gone;
    fbc_pkg::fbc_state_t st_q;
    fbc_pkg::fbc_mode_t mode_q;
    fbc_pkg::fbc_section_t sec_q;

    // Single free-running millisecond tick
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // Sample on the tick unless the efficiency pause is running
    assign sample_now = tick_q && (pause_q == 7'h00);
    assign mains_gone = disc_q || brownout_o;

    // Pause after mains confirmed; longer pause in burst
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pause_q <= 7'h00;
        end else if (sample_now && mains_present_o && !disc_q) begin
            pause_q <= (mode_q == fbc_pkg::FBC_MODE_BURST) ?
                7'(fbc_pkg::PAUSE_BURST_MS) : 7'(fbc_pkg::PAUSE_MS);
        end else if (tick_q && pause_q != 7'h00) begin
            pause_q <= pause_q - 1'b1;
        end
    end

    // Slope detection: a crossing between consecutive samples
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            prev_q <= 2'h0;
            mains_present_o <= 1'b0;
            slope_cnt_q <= 5'h00;
            disc_q <= 1'b0;
        end else begin
            if (sample_now) begin
                prev_q <= {mains_i.above_mains_high, mains_i.above_brownin};
            end
            if (sample_now && ((mains_i.above_brownin && !prev_q[0]) ||
                    (mains_i.above_mains_high && !prev_q[1]))) begin
                mains_present_o <= 1'b1;
                slope_cnt_q <= 5'h00;
                disc_q <= 1'b0;
            end else if (tick_q && pause_q == 7'h00) begin
                // Pause time is excluded so a long burst pause is no false loss
                if (slope_cnt_q == 5'(fbc_pkg::DISCONNECT_MS - 1)) begin
                    disc_q <= 1'b1;
                    mains_present_o <= 1'b0;
                end else begin
                    slope_cnt_q <= slope_cnt_q + 1'b1;
                end
            end
        end
    end

    // Brownout: every sample low for 30 ms without break
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            low_cnt_q <= 5'h00;
            brownout_o <= 1'b0;
        end else if (sample_now) begin
            if (!mains_i.below_brownout) begin
                low_cnt_q <= 5'h00;
                if (mains_i.above_brownin) begin
                    brownout_o <= 1'b0;
                end
            end else if (low_cnt_q == 5'(fbc_pkg::BROWNOUT_MS - 1)) begin
                brownout_o <= 1'b1;
            end else begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end

    // Mains pin pulled during samples, held low once disconnected
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mains_sense_pin_o <= 1'b0;
            mains_sample_o <= 1'b0;
        end else begin
            mains_sample_o <= sample_now;
            mains_sense_pin_o <= sample_now || disc_q;
        end
    end

    // External fault filter, clocked by ms tick in the band, below it by ticks during gate pulses
    assign protect_ok = fault_detect_i;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            filt_cnt_q <= 2'h0;
        end else if (protect_ok || st_q == fbc_pkg::FBC_ST_LATCH) begin
            filt_cnt_q <= 2'h0;
        end else if (fault_above_power_down_threshold_i ? tick_q :
                (gate_o && tick_q)) begin
            // In the band the tick drives the count; below it pulses gate it
            if (filt_cnt_q != 2'(fbc_pkg::FAULT_FILT_MS)) begin
                filt_cnt_q <= filt_cnt_q + 1'b1;
            end
        end
    end

    // Overvoltage: consecutive pulses sampled in the output section
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ovp_cnt_q <= 3'h0;
            ovp_latched_o <= 1'b0;
        end else if (mains_gone) begin
            ovp_cnt_q <= 3'h0;
            ovp_latched_o <= 1'b0;
        end else if (sec_q == fbc_pkg::FBC_SEC_OUTPUT && demag_i) begin
            // One decision per secondary stroke, at its start
            if (overvoltage_protection_i) begin
                if (ovp_cnt_q == 3'(fbc_pkg::OVP_PULSES - 1)) begin
                    ovp_latched_o <= 1'b1;
                end else begin
                    ovp_cnt_q <= ovp_cnt_q + 1'b1;
                end
            end else begin
                ovp_cnt_q <= 3'h0;
            end
        end
    end

    // Overpower timer and limit depend on startup phase
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            started_q <= 1'b0;
            opp_cnt_q <= 8'h00;
            power_limit_o <= fbc_pkg::LIMIT_100;
        end else begin
            if (st_q != fbc_pkg::FBC_ST_RUN) begin
                started_q <= 1'b0;
            end else if (fb_below_5v_i) begin
                started_q <= 1'b1;
            end
            power_limit_o <= started_q ? fbc_pkg::LIMIT_150 : fbc_pkg::LIMIT_100;
            if (st_q != fbc_pkg::FBC_ST_RUN || !above_overpower_timer_reference_i) begin
                opp_cnt_q <= 8'h00;
            end else if (tick_q && !opp_trip) begin
                opp_cnt_q <= opp_cnt_q + 1'b1;
            end
        end
    end
    assign opp_trip = started_q ? (opp_cnt_q >= 8'(fbc_pkg::OPP_RUN_MS)) :
        (opp_cnt_q >= 8'(fbc_pkg::OPP_START_MS));

    // Top-level protection state machine
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_q <= fbc_pkg::FBC_ST_WAIT;
            rst_cnt_q <= 10'h000;
        end else begin
            case (st_q)
                fbc_pkg::FBC_ST_WAIT: begin
                    if (mains_present_o && !mains_gone && mains_i.above_brownin &&
                            protect_ok && !undervoltage_lockout_i) begin
                        st_q <= fbc_pkg::FBC_ST_RUN;
                    end
                end
                fbc_pkg::FBC_ST_RUN: begin
                    if (mains_gone) begin
                        st_q <= fbc_pkg::FBC_ST_BROWN;
                    end else if (ovp_latched_o ||
                            filt_cnt_q == 2'(fbc_pkg::FAULT_FILT_MS)) begin
                        st_q <= fbc_pkg::FBC_ST_LATCH;
                    end else if (opp_trip || max_on_time_i ||
                            (above_overpower_timer_reference_i && undervoltage_lockout_i)) begin
                        st_q <= fbc_pkg::FBC_ST_RESTART;
                        rst_cnt_q <= 10'h000;
                    end
                end
                fbc_pkg::FBC_ST_RESTART: begin
                    if (mains_gone) begin
                        st_q <= fbc_pkg::FBC_ST_WAIT;
                    end else if (rst_cnt_q == 10'(fbc_pkg::RESTART_MS)) begin
                        st_q <= fbc_pkg::FBC_ST_WAIT;
                    end else if (tick_q) begin
                        rst_cnt_q <= rst_cnt_q + 1'b1;
                    end
                end
                fbc_pkg::FBC_ST_LATCH: begin
                    if (mains_gone) begin
                        st_q <= fbc_pkg::FBC_ST_WAIT;
                    end
                end
                fbc_pkg::FBC_ST_BROWN: begin
                    if (!mains_gone) begin
                        st_q <= fbc_pkg::FBC_ST_WAIT;
                    end
                end
                default: begin
                    st_q <= fbc_pkg::FBC_ST_WAIT;
                end
            endcase
        end
    end

    // Operating mode follows the load requests
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_q <= fbc_pkg::FBC_MODE_VALLEY;
        end else if (load_i.burst_request) begin
            mode_q <= fbc_pkg::FBC_MODE_BURST;
        end else if (load_i.slow_request) begin
            mode_q <= fbc_pkg::FBC_MODE_SLOW;
        end else if (load_i.freq_at_max) begin
            mode_q <= fbc_pkg::FBC_MODE_DCM;
        end else begin
            mode_q <= fbc_pkg::FBC_MODE_VALLEY;
        end
    end

    // Switching cycle sections and gate drive
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sec_q <= fbc_pkg::FBC_SEC_VALLEY;
            gate_o <= 1'b0;
            per_cnt_q <= '0;
        end else begin
            per_cnt_q <= per_cnt_q + 1'b1;
            case (sec_q)
                fbc_pkg::FBC_SEC_INPUT: begin
                    // Winding shows input voltage while on
                    // Mains loss ends the pulse without waiting for the state change
                    if (above_cycle_limit_reference_i || st_q != fbc_pkg::FBC_ST_RUN ||
                            mains_gone) begin
                        gate_o <= 1'b0;
                        sec_q <= fbc_pkg::FBC_SEC_OUTPUT;
                    end
                end
                fbc_pkg::FBC_SEC_OUTPUT: begin
                    if (demag_i) begin
                        sec_q <= fbc_pkg::FBC_SEC_DEMAG;
                    end
                end
                fbc_pkg::FBC_SEC_DEMAG: begin
                    sec_q <= fbc_pkg::FBC_SEC_VALLEY;
                end
                fbc_pkg::FBC_SEC_VALLEY: begin
                    // Oscillator modes also wait for the set period; the cap keeps 25 kHz
                    if (st_q == fbc_pkg::FBC_ST_RUN && valley_i && !mains_gone &&
                            (mode_q == fbc_pkg::FBC_MODE_VALLEY ||
                             per_cnt_q >= osc_period_i ||
                             per_cnt_q >= PER_W'(fbc_pkg::MAX_PERIOD_CYC))) begin
                        gate_o <= 1'b1;
                        sec_q <= fbc_pkg::FBC_SEC_INPUT;
                        per_cnt_q <= '0;
                    end
                end
                default: begin
                    sec_q <= fbc_pkg::FBC_SEC_VALLEY;
                end
            endcase
        end
    end

    // Supply regulated through mains pin whenever stopped or before start
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            supply_regulate_o <= 1'b1;
        end else begin
            supply_regulate_o <= (st_q != fbc_pkg::FBC_ST_RUN) || !started_q;
        end
    end

    assign mode_o = mode_q;
    assign state_o = st_q;
    assign section_o = sec_q;
endmodule

`default_nettype wire

// ---- rtl/fbc_pkg.sv ----
// Package for the flyback mode and protection supervisor.
// Assumes a 50 MHz core clock; all millisecond timers share one tick.
package fbc_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
    localparam int unsigned BROWNOUT_MS = 30;
    localparam int unsigned PAUSE_MS = 6;
    localparam int unsigned PAUSE_BURST_MS = 97;
    localparam int unsigned DISCONNECT_MS = 28;
    localparam int unsigned FAULT_FILT_MS = 3;
    localparam int unsigned OVP_PULSES = 4;
    localparam int unsigned OPP_RUN_MS = 200;
    localparam int unsigned OPP_START_MS = 40;
    localparam int unsigned RESTART_MS = 800;
    localparam int unsigned MIN_FREQ_KHZ = 25;
    localparam int unsigned MAX_PERIOD_CYC = CLK_HZ / (MIN_FREQ_KHZ * 1000);
    localparam logic [1:0] LIMIT_100 = 2'h0;
    localparam logic [1:0] LIMIT_150 = 2'h1;

    typedef enum logic [1:0] {
        FBC_MODE_VALLEY = 2'h0,
        FBC_MODE_DCM = 2'h1,
        FBC_MODE_SLOW = 2'h3,
        FBC_MODE_BURST = 2'h2
    } fbc_mode_t;

    typedef enum logic [2:0] {
        FBC_ST_WAIT = 3'h0,
        FBC_ST_RUN = 3'h1,
        FBC_ST_RESTART = 3'h3,
        FBC_ST_LATCH = 3'h2,
        FBC_ST_BROWN = 3'h6
    } fbc_state_t;

    typedef enum logic [1:0] {
        FBC_SEC_INPUT = 2'h0,
        FBC_SEC_OUTPUT = 2'h1,
        FBC_SEC_DEMAG = 2'h3,
        FBC_SEC_VALLEY = 2'h2
    } fbc_section_t;

    // Comparator results from the analogue front end
    typedef struct packed {
        logic above_brownin;
        logic above_mains_high;
        logic below_brownout;
    } fbc_mains_t;

    typedef struct packed {
        logic freq_at_max;
        logic slow_request;
        logic burst_request;
    } fbc_load_t;
endpackage

// ---- dv/fbc_supervisor_assertions.sv ----
// Port-level checker for the flyback supervisor.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fbc_supervisor_assertions #(
    parameter int unsigned TICK_CYC = 50
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Watched inputs
    input wire logic valley_i,
    input wire logic above_cycle_limit_reference_i,
    input wire logic above_overpower_timer_reference_i,
    input wire logic undervoltage_lockout_i,
    // Watched outputs
    input wire logic mains_sample_o,
    input wire logic gate_o,
    input wire logic supply_regulate_o,
    input wire logic brownout_o,
    input wire logic ovp_latched_o,
    input wire fbc_pkg::fbc_mode_t mode_o,
    input wire fbc_pkg::fbc_state_t state_o
);
    int unsigned gap_q;
    // Cycles since last sample; reset starts full so the first sample passes
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            gap_q <= TICK_CYC;
        end else if (mains_sample_o) begin
            gap_q <= 0;
        end else if (gap_q < TICK_CYC) begin
            gap_q <= gap_q + 1;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sample_spacing_a: assert property (mains_sample_o |-> gap_q >= TICK_CYC - 1)
        else $error("mains samples closer than one tick");
    gate_run_a: assert property ($rose(gate_o)
        |-> $past(state_o) == fbc_pkg::FBC_ST_RUN)
        else $error("gate started outside run state");
    valley_start_a: assert property ($rose(gate_o) && mode_o == fbc_pkg::FBC_MODE_VALLEY
        |-> $past(valley_i)) else $error("valley mode gate without valley");
    cycle_limit_a: assert property (gate_o && above_cycle_limit_reference_i |=> !gate_o)
        else $error("gate kept on above cycle limit");
    brownout_stop_a: assert property ($rose(brownout_o) |-> ##[0:1] !gate_o ##1 !gate_o)
        else $error("switching after brownout");
    stopped_supply_a: assert property ((state_o != fbc_pkg::FBC_ST_RUN) [*2]
        |-> supply_regulate_o) else $error("no supply regulation while stopped");
    undervoltage_lockout_trip_a: assert property (state_o == fbc_pkg::FBC_ST_RUN && undervoltage_lockout_i
        && above_overpower_timer_reference_i |-> ##[1:3] state_o == fbc_pkg::FBC_ST_RESTART)
        else $error("overpower with undervoltage did not trip");
    ovp_stop_a: assert property ($rose(ovp_latched_o)
        |-> ##[0:2] (state_o == fbc_pkg::FBC_ST_LATCH && !gate_o))
        else $error("overvoltage did not latch off");
endmodule
bind fbc_supervisor fbc_supervisor_assertions #(.TICK_CYC(TICK_CYC)) i_fbc_supervisor_assertions (
    .core_clk_i, .sys_rst_i, .valley_i, .above_cycle_limit_reference_i,
    .above_overpower_timer_reference_i, .undervoltage_lockout_i, .mains_sample_o,
    .gate_o, .supply_regulate_o, .brownout_o, .ovp_latched_o, .mode_o, .state_o
);
`default_nettype wire

// ---- dv/fbc_stage_model.sv ----
// Power stage, auxiliary winding and mains source model.
// Assumes the bench commands mains and overvoltage; shared clock.
`timescale 1ns/1ps
`default_nettype none
module fbc_stage_model (
    // Clock and commands
    input wire logic clk_i,
    input wire logic mains_on_i,
    input wire logic ovp_on_i,
    // Design side
    input wire logic gate_i,
    input wire logic sample_i,
    output fbc_pkg::fbc_mains_t mains_o,
    output logic demag_o,
    output logic valley_o,
    output logic ovp_o,
    output logic lim_o
);
    int unsigned cnt = 0;
    logic hi = 1'b0;
    logic g_q = 1'b0;
    initial {mains_o, demag_o, valley_o, ovp_o, lim_o} = '0;
    // Mains level flips per sample, so rising crossings keep coming
    always @(negedge clk_i) begin
        if (sample_i) hi <= !hi;
        mains_o <= '{mains_on_i, mains_on_i && hi, !mains_on_i};
    end
    // Stroke timing: ramp while on, demag after turn-off, then ringing
    always @(negedge clk_i) begin
        g_q <= gate_i;
        cnt <= (gate_i != g_q) ? 0 : cnt + 1;
        lim_o <= gate_i && g_q && cnt >= 3;
        demag_o <= !gate_i && cnt < 6;
        ovp_o <= ovp_on_i && !gate_i && cnt < 6;
        valley_o <= !gate_i && cnt >= 8 && cnt % 4 == 0;
    end
endmodule
`default_nettype wire

// ---- dv/fbc_supervisor_tb_top.sv ----
// Self-checking bench for the flyback supervisor.
// Assumes a short tick parameter; stage model supplies winding and mains.
`timescale 1ns/1ps
`default_nettype none
module fbc_supervisor_tb_top;
    localparam int unsigned TK = 30;
    localparam int unsigned LIMIT = 90000;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    fbc_pkg::fbc_load_t load = '0;
    logic undervoltage_lockout = 1'b0, fb5 = 1'b0, fdet = 1'b1, fband = 1'b0;
    logic oppr = 1'b0, mon = 1'b0, ovpc = 1'b0, mot = 1'b0;
    logic pin, smp, sreg, gate, dem, val, overvoltage_protection, lim, bo, pres, ovpl;
    logic [1:0] plim;
    fbc_pkg::fbc_mains_t mains;
    fbc_pkg::fbc_mode_t mode;
    fbc_pkg::fbc_state_t st;
    fbc_pkg::fbc_section_t sec;
    int errors = 0, tests_run = 0, cyc = 0;
    // Clock
    always #10 core_clk_i = !core_clk_i;
    fbc_supervisor #(.TICK_CYC(TK), .PER_W(12)) i_fbc_supervisor (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .mains_i(mains),
        .mains_sense_pin_o(pin), .mains_sample_o(smp), .supply_regulate_o(sreg),
        .load_i(load), .demag_i(dem), .valley_i(val), .overvoltage_protection_i(overvoltage_protection),
        .osc_period_i(12'h100), .above_cycle_limit_reference_i(lim),
        .above_overpower_timer_reference_i(oppr), .undervoltage_lockout_i(undervoltage_lockout),
        .fb_below_5v_i(fb5), .fault_detect_i(fdet),
        .fault_above_power_down_threshold_i(fband), .max_on_time_i(mot),
        .gate_o(gate), .mode_o(mode), .state_o(st), .section_o(sec), .brownout_o(bo),
        .mains_present_o(pres), .ovp_latched_o(ovpl), .power_limit_o(plim)
    );
    fbc_stage_model i_fbc_stage_model (
        .clk_i(core_clk_i), .mains_on_i(mon), .ovp_on_i(ovpc), .gate_i(gate),
        .sample_i(smp), .mains_o(mains), .demag_o(dem), .valley_o(val),
        .ovp_o(overvoltage_protection), .lim_o(lim)
    );
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n * TK) @(negedge core_clk_i);
    endtask
    // Bounded wait for a state, then compare
    task automatic wait_st(input fbc_pkg::fbc_state_t s, input int lim_c);
        for (int i = 0; i < lim_c && st !== s; i++) @(negedge core_clk_i);
        check(st, s);
    endtask
    // Cycles between two mains samples
    task automatic gap(output int n);
        n = 0;
        @(posedge smp);
        @(negedge core_clk_i);
        do begin
            @(negedge core_clk_i);
            n++;
        end while (smp !== 1'b1 && n < 5000);
    endtask
    // Pull the mains, expect shutdown, then bring it back
    task automatic recover();
        mon = 1'b0;
        for (int i = 0; i < 300 * TK && bo !== 1'b1; i++) @(negedge core_clk_i);
        check(bo, 1'b1);
        check(gate, 1'b0);
        check(pin, 1'b1);
        ticks(1);
        check(pin, 1'b1);
        check(st !== fbc_pkg::FBC_ST_LATCH, 1'b1);
        mon = 1'b1;
        wait_st(fbc_pkg::FBC_ST_RUN, 60 * TK);
    endtask
    task automatic t_start();
        int n;
        ticks(3);
        check(gate, 1'b0);
        check(pres, 1'b0);
        gap(n);
        check(n, TK);
        mon = 1'b1;
        wait_st(fbc_pkg::FBC_ST_RUN, 40 * TK);
        check(pres, 1'b1);
        // Walk one switching cycle through its sections
        @(posedge gate);
        @(negedge core_clk_i);
        check(sec, fbc_pkg::FBC_SEC_INPUT);
        @(negedge gate);
        @(negedge core_clk_i);
        check(sec, fbc_pkg::FBC_SEC_OUTPUT);
        repeat (2) @(negedge core_clk_i);
        check(sec, fbc_pkg::FBC_SEC_VALLEY);
        repeat (2) gap(n);
        check(n, (fbc_pkg::PAUSE_MS + 1) * TK);
        $display("t_start done");
    endtask
    task automatic t_modes();
        fbc_pkg::fbc_load_t lv [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
        fbc_pkg::fbc_mode_t mv [4] = '{fbc_pkg::FBC_MODE_DCM, fbc_pkg::FBC_MODE_SLOW,
            fbc_pkg::FBC_MODE_BURST, fbc_pkg::FBC_MODE_VALLEY};
        int n;
        for (int i = 0; i < 4; i++) begin
            load = lv[i];
            repeat (40) @(negedge core_clk_i);
            check(mode, mv[i]);
            if (i == 2) begin
                repeat (2) gap(n);
                check(n, (fbc_pkg::PAUSE_BURST_MS + 1) * TK);
            end
        end
        $display("t_modes done");
    endtask
    // Overvoltage on n strokes, after one clean stroke
    task automatic pulses(input int n);
        repeat (2) @(posedge gate);
        @(negedge core_clk_i);
        ovpc = 1'b1;
        repeat (n) @(negedge gate);
        repeat (7) @(negedge core_clk_i);
        ovpc = 1'b0;
    endtask
    task automatic t_ovp();
        pulses(3);
        check(ovpl, 1'b0);
        pulses(4);
        check(ovpl, 1'b1);
        wait_st(fbc_pkg::FBC_ST_LATCH, 10);
        check(sreg, 1'b1);
        recover();
        $display("t_ovp done");
    endtask
    task automatic t_fault();
        fdet = 1'b0;
        fband = 1'b1;
        ticks(2);
        check(st, fbc_pkg::FBC_ST_RUN);
        wait_st(fbc_pkg::FBC_ST_LATCH, 2 * TK + 5);
        check(sreg, 1'b1);
        fdet = 1'b1;
        fband = 1'b0;
        recover();
        $display("t_fault done");
    endtask
    task automatic t_opp();
        check(plim, fbc_pkg::LIMIT_100);
        oppr = 1'b1;
        ticks(fbc_pkg::OPP_START_MS - 2);
        check(st, fbc_pkg::FBC_ST_RUN);
        wait_st(fbc_pkg::FBC_ST_RESTART, 4 * TK);
        oppr = 1'b0;
        ticks(fbc_pkg::RESTART_MS - 6);
        check(st, fbc_pkg::FBC_ST_RESTART);
        wait_st(fbc_pkg::FBC_ST_RUN, 12 * TK);
        fb5 = 1'b1;
        repeat (3) @(negedge core_clk_i);
        check(plim, fbc_pkg::LIMIT_150);
        check(sreg, 1'b0);
        undervoltage_lockout = 1'b1;
        oppr = 1'b1;
        wait_st(fbc_pkg::FBC_ST_RESTART, 5);
        undervoltage_lockout = 1'b0;
        oppr = 1'b0;
        recover();
        $display("t_opp done");
    endtask
    // Maximum on-time stops switching and enters safe restart
    task automatic t_ontime();
        ticks(1);
        check(sreg, 1'b0);
        mot = 1'b1;
        wait_st(fbc_pkg::FBC_ST_RESTART, 5);
        mot = 1'b0;
        @(negedge core_clk_i);
        check(sreg, 1'b1);
        recover();
        $display("t_ontime done");
    endtask
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            $display("Error at %0t: run too long", $time);
            close_out();
        end
    end
    initial begin
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        t_start();
        t_modes();
        t_ovp();
        t_fault();
        t_opp();
        t_ontime();
        close_out();
    end
endmodule
`default_nettype wire
